// File: hdl/rcpm_reset_ctrl.sv
// Purpose: reset controller making processor, peripheral and reset pin resets
// Assumes: mclk acts as the slow clock; reset_n is the power-on reset
// Notes: registers reached over classic Wishbone, one-cycle registered ack
//
// What this block does
// - all logic on one clock; three active-low resets: processor, peripheral, pin.
// - peripheral reset line resets every embedded peripheral.
// - pin, peripheral and processor resets driven separately or together per cause.
// - resets come from pin events or software commands; state manager chooses lines.
// - state manager requests the pin manager whenever the pin must go low.
// - pin manager holds the pin low for a programmed time.
// - after power-up a startup counter holds resets for the oscillator startup time.
// - last reset cause is recorded for software to read.
// - pin sampled each clock; low level reports a user reset request.
// - user reset enable at 0 stops a low pin from causing reset.
// - status bit shows the sampled pin level at any time.
// - user reset status sets on pin assertion, clears when status is read.
// - with interrupt enable at 1, pin assertion interrupts instead of resetting.
// - pulse lasts two to the power of field plus one cycles.
// - user reset ends after pin rises, resync then three startup cycles.
// - releasing processor reset after user reset loads the user reset code.
// - soft and startup resets end on their own count even if the pin is held low externally.
`timescale 1ns/1ps
`default_nettype none
module rcpm_reset_ctrl
    import rcpm_pkg::*;
#(
    parameter int STARTUP_CYCLES = STARTUP_CYCLES_DEF
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic reset_pin_i,
    output logic reset_pin_o,
    output logic reset_pin_oe,
    output logic proc_nreset,
    output logic periph_nreset,
    output logic user_reset_irq
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        rcpm_state_t state;
        logic [31:0] startup_cnt;
        logic [1:0] seq_cnt;
        logic user_reset_enable;
        logic user_reset_irq_enable;
        logic [LEN_W-1:0] ext_pulse_length_field;
        logic user_reset_status;
        logic [TYPE_W-1:0] last_reset_type;
        logic soft_proc;
        logic soft_periph;
        logic soft_busy;
        logic level_prev;
        logic pulse_req;
        logic proc_nreset;
        logic periph_nreset;
        logic irq;
        logic ack;
        logic [31:0] dat;
    } rcpm_top_t;

    rcpm_top_t s;
    rcpm_top_t n;

    logic pin_level;
    logic pin_user_req;
    logic access;
    logic wr;
    logic rd_status;
    logic soft_write;
    logic user_trigger;
    logic pin_fell;
    logic [31:0] mode_word;
    logic [31:0] mode_new;
    logic [31:0] status_word;

    // byte-lane merge of a write into a held word
    function automatic logic [31:0] wb_merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                            input logic [3:0] sel);
        logic [31:0] r;
        r = old_w;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[8*i +: 8] = new_w[8*i +: 8];
            end
        end
        return r;
    endfunction

    // ----------------------------------------------------------------
    // pin manager
    // ----------------------------------------------------------------
    rcpm_pin_mgr u_pin (
        .mclk(mclk),
        .reset_n(reset_n),
        .pin_i(reset_pin_i),
        .pulse_req(s.pulse_req),
        .pulse_len(s.ext_pulse_length_field),
        .pin_o(reset_pin_o),
        .pin_oe(reset_pin_oe),
        .pin_level(pin_level),
        .pin_user_req(pin_user_req)
    );

    // ----------------------------------------------------------------
    // register views
    // ----------------------------------------------------------------
    always_comb begin
        mode_word = '0;
        mode_word[MODE_URST_EN_BIT] = s.user_reset_enable;
        mode_word[MODE_IRQ_EN_BIT] = s.user_reset_irq_enable;
        mode_word[MODE_LEN_LSB +: LEN_W] = s.ext_pulse_length_field;
        status_word = '0;
        status_word[STAT_URST_BIT] = s.user_reset_status;
        status_word[STAT_TYPE_LSB +: TYPE_W] = s.last_reset_type;
        status_word[STAT_PIN_BIT] = pin_level;
        status_word[STAT_BUSY_BIT] = s.soft_busy;
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        n = s;
        access = wb_cyc_i & wb_stb_i & ~s.ack;
        wr = access & wb_we_i;
        rd_status = access & ~wb_we_i & (wb_adr_i == ADDR_STATUS);
        mode_new = wb_merge(mode_word, wb_dat_i, wb_sel_i);
        // commands are only taken while running; busy or in reset they are dropped
        soft_write = wr & (wb_adr_i == ADDR_CTRL) & wb_sel_i[0] & (s.state == RCPM_RUN) &
                     (wb_dat_i[CTRL_PROC_BIT] | wb_dat_i[CTRL_PERIPH_BIT] |
                      wb_dat_i[CTRL_EXT_BIT]);
        user_trigger = pin_user_req & s.user_reset_enable & ~s.user_reset_irq_enable;
        pin_fell = s.level_prev & ~pin_level;

        n.ack = access;
        n.pulse_req = 1'b0;
        n.level_prev = pin_level;

        // bus slave: unmapped reads give zero, unmapped writes are dropped
        if (access && !wb_we_i) begin
            unique case (wb_adr_i)
                ADDR_MODE: n.dat = mode_word;
                ADDR_STATUS: n.dat = status_word;
                default: n.dat = '0;
            endcase
        end
        if (wr && wb_adr_i == ADDR_MODE) begin
            n.user_reset_enable = mode_new[MODE_URST_EN_BIT];
            n.user_reset_irq_enable = mode_new[MODE_IRQ_EN_BIT];
            n.ext_pulse_length_field = mode_new[MODE_LEN_LSB +: LEN_W];
        end

        // a fresh assertion in the read cycle survives the clear
        n.user_reset_status = pin_fell | (s.user_reset_status & ~rd_status);

        unique case (s.state)
            RCPM_STARTUP: begin
                n.startup_cnt = s.startup_cnt + 32'h1;
                if (s.startup_cnt >= 32'(STARTUP_CYCLES - 1)) begin
                    n.state = RCPM_RUN;
                    n.last_reset_type = TYPE_POWERUP;
                end
            end
            RCPM_RUN: begin
                if (soft_write) begin
                    n.state = RCPM_SOFT;
                    n.seq_cnt = '0;
                    n.soft_busy = 1'b1;
                    n.soft_proc = wb_dat_i[CTRL_PROC_BIT];
                    n.soft_periph = wb_dat_i[CTRL_PERIPH_BIT];
                    n.pulse_req = wb_dat_i[CTRL_EXT_BIT];
                end else if (user_trigger) begin
                    n.state = RCPM_USER;
                end
            end
            RCPM_SOFT: begin
                // the pin has no effect here
                n.seq_cnt = s.seq_cnt + 2'h1;
                if (s.seq_cnt == SOFT_LAST) begin
                    n.state = RCPM_RUN;
                    n.soft_busy = 1'b0;
                    if (s.soft_proc) begin
                        n.last_reset_type = TYPE_SOFT;
                    end
                end
            end
            RCPM_USER: begin
                n.seq_cnt = '0;
                if (pin_level) begin
                    n.state = RCPM_USER_EXIT;
                end
            end
            RCPM_USER_EXIT: begin
                n.seq_cnt = s.seq_cnt + 2'h1;
                if (!pin_level) begin
                    n.state = RCPM_USER;
                end else if (s.seq_cnt == USER_EXIT_LAST) begin
                    n.state = RCPM_RUN;
                    n.last_reset_type = TYPE_USER;
                end
            end
            default: begin
                n.state = RCPM_STARTUP;
                n.startup_cnt = '0;
            end
        endcase

        // outputs follow the next state so a command bites on the following edge
        n.proc_nreset = ~((n.state == RCPM_STARTUP) | (n.state == RCPM_USER) |
                          (n.state == RCPM_USER_EXIT) |
                          ((n.state == RCPM_SOFT) & n.soft_proc));
        n.periph_nreset = ~((n.state == RCPM_STARTUP) | (n.state == RCPM_USER) |
                            (n.state == RCPM_USER_EXIT) |
                            ((n.state == RCPM_SOFT) & n.soft_periph));
        n.irq = n.user_reset_status & n.user_reset_irq_enable;
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            s <= '{state: RCPM_STARTUP, startup_cnt: '0, seq_cnt: '0,
                   user_reset_enable: URST_EN_RESET, user_reset_irq_enable: IRQ_EN_RESET,
                   ext_pulse_length_field: LEN_RESET, user_reset_status: 1'b0,
                   last_reset_type: TYPE_POWERUP, soft_proc: 1'b0, soft_periph: 1'b0,
                   soft_busy: 1'b0, level_prev: 1'b1, pulse_req: 1'b0,
                   proc_nreset: 1'b0, periph_nreset: 1'b0, irq: 1'b0, ack: 1'b0,
                   dat: '0};
        end else begin
            s <= n;
        end
    end

    assign wb_dat_o = s.dat;
    assign wb_ack_o = s.ack;
    assign proc_nreset = s.proc_nreset;
    assign periph_nreset = s.periph_nreset;
    assign user_reset_irq = s.irq;

endmodule
`default_nettype wire

// File: hdl/rcpm_pkg.sv
// Purpose: shared constants and types of the reset controller and its reset pin manager
// Assumes: one clock (mclk, 200 MHz) stands in for the slow clock
// Notes: register offsets are byte addresses on a 32-bit classic Wishbone slave
package rcpm_pkg;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ = 200;
    localparam int STARTUP_TIME_US = 1500;
    localparam int STARTUP_CYCLES_DEF = STARTUP_TIME_US * CLK_MHZ;
    localparam int SOFT_CYCLES = 3;
    localparam int USER_EXIT_CYCLES = 3;
    localparam logic [1:0] SOFT_LAST = 2'(SOFT_CYCLES - 1);
    localparam logic [1:0] USER_EXIT_LAST = 2'(USER_EXIT_CYCLES - 1);
    localparam int LEN_W = 4;
    localparam int PULSE_CNT_W = 17;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam int ADR_W = 4;
    localparam logic [3:0] ADDR_MODE = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_CTRL = 4'h8;
    localparam int MODE_URST_EN_BIT = 0;
    localparam int MODE_IRQ_EN_BIT = 4;
    localparam int MODE_LEN_LSB = 8;
    localparam int STAT_URST_BIT = 0;
    localparam int STAT_TYPE_LSB = 8;
    localparam int STAT_PIN_BIT = 16;
    localparam int STAT_BUSY_BIT = 17;
    localparam int CTRL_PROC_BIT = 0;
    localparam int CTRL_PERIPH_BIT = 2;
    localparam int CTRL_EXT_BIT = 3;
    localparam logic URST_EN_RESET = 1'b1;
    localparam logic IRQ_EN_RESET = 1'b0;
    localparam logic [LEN_W-1:0] LEN_RESET = 4'h0;

    // ----------------------------------------------------------------
    // last reset type codes
    // ----------------------------------------------------------------
    localparam int TYPE_W = 3;
    localparam logic [TYPE_W-1:0] TYPE_POWERUP = 3'h0;
    localparam logic [TYPE_W-1:0] TYPE_SOFT = 3'h3;
    localparam logic [TYPE_W-1:0] TYPE_USER = 3'h4;

    typedef enum logic [2:0] {
        RCPM_STARTUP = 3'b000,
        RCPM_RUN = 3'b001,
        RCPM_SOFT = 3'b010,
        RCPM_USER = 3'b011,
        RCPM_USER_EXIT = 3'b100
    } rcpm_state_t;

    // pulse length is 2^(field+1) cycles; 5-bit sum keeps field 15 from wrapping
    function automatic logic [PULSE_CNT_W-1:0] pulse_cycles(input logic [LEN_W-1:0] f);
        logic [4:0] sh;
        sh = {1'b0, f} + 5'h1;
        return {{(PULSE_CNT_W-1){1'b0}}, 1'b1} << sh;
    endfunction

endpackage

// File: hdl/rcpm_pin_mgr.sv
// Purpose: samples the bidirectional active-low reset pin and shapes its outgoing pulse
// Assumes: pin is open drain with an external pull-up
// Notes: own pulses are masked from the user reset request until the pin is seen high again
`timescale 1ns/1ps
`default_nettype none
module rcpm_pin_mgr
    import rcpm_pkg::*;
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic pin_i,
    input wire logic pulse_req,
    input wire logic [LEN_W-1:0] pulse_len,
    output logic pin_o,
    output logic pin_oe,
    output logic pin_level,
    output logic pin_user_req
);

    typedef struct packed {
        logic [2:0] sync;
        logic level;
        logic driving;
        logic own;
        logic seen_low;
        logic [PULSE_CNT_W-1:0] cnt;
        logic o;
        logic user_req;
    } rcpm_pin_t;

    rcpm_pin_t s;
    rcpm_pin_t n;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        n = s;
        n.sync = {s.sync[1:0], pin_i};
        // a change counts only once second and third stages agree
        if (s.sync[1] == s.sync[2]) begin
            n.level = s.sync[2];
        end
        if (s.driving) begin
            if (s.cnt == '0) begin
                n.driving = 1'b0;
            end else begin
                n.cnt = s.cnt - {{(PULSE_CNT_W-1){1'b0}}, 1'b1};
            end
        end else if (pulse_req) begin
            n.driving = 1'b1;
            n.own = 1'b1;
            n.seen_low = 1'b0;
            n.cnt = pulse_cycles(pulse_len) - {{(PULSE_CNT_W-1){1'b0}}, 1'b1};
        end
        if (s.own && !s.level) begin
            n.seen_low = 1'b1;
        end
        // limitation: a pin that never goes low keeps the mask set
        if (s.own && s.seen_low && s.level && !s.driving && !pulse_req) begin
            n.own = 1'b0;
        end
        n.o = ~n.driving;
        n.user_req = ~n.level & ~n.own;
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            s <= '{sync: 3'h7, level: 1'b1, driving: 1'b0, own: 1'b0, seen_low: 1'b0,
                   cnt: '0, o: 1'b1, user_req: 1'b0};
        end else begin
            s <= n;
        end
    end

    assign pin_o = s.o;
    assign pin_oe = s.driving;
    assign pin_level = s.level;
    assign pin_user_req = s.user_req;

endmodule
`default_nettype wire

// File: test/rcpm_reset_ctrl_props.sv
// Purpose: port checker of the reset controller
// Assumes: bound into rcpm_reset_ctrl
// Notes: pulse length shadowed from bus writes; a length change mid-pulse is not covered
`timescale 1ns/1ps
`default_nettype none
module rcpm_reset_ctrl_props
    import rcpm_pkg::*;
#(
    parameter int STARTUP_CYCLES = 20
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic reset_pin_i,
    input wire logic reset_pin_o,
    input wire logic reset_pin_oe,
    input wire logic proc_nreset,
    input wire logic periph_nreset,
    input wire logic user_reset_irq
);
    // ----------------------------------------------------------------
    // helper logic
    // ----------------------------------------------------------------
    logic [LEN_W-1:0] len;
    logic [PULSE_CNT_W-1:0] hcnt;
    int scnt;
    wire logic ctrl_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == ADDR_CTRL
                         && wb_dat_i[CTRL_EXT_BIT];
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            len <= LEN_RESET;
            hcnt <= '0;
            scnt <= 0;
        end else begin
            if (wb_ack_o && wb_we_i && wb_adr_i == ADDR_MODE && wb_sel_i[1]) begin
                len <= wb_dat_i[MODE_LEN_LSB +: LEN_W];
            end
            hcnt <= reset_pin_oe ? hcnt + 1'b1 : '0;
            if (scnt < STARTUP_CYCLES) begin
                scnt <= scnt + 1;
            end
        end
    end
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);
    sequence s_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_ext_low;
        !reset_pin_i && !reset_pin_oe && !proc_nreset;
    endsequence
    a_ack_follow: assert property (s_take |=> wb_ack_o)
        else $error("ack missing after request");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_pin_drive_low: assert property (reset_pin_oe |-> !reset_pin_o)
        else $error("pin driven high");
    a_pulse_cause: assert property ($rose(reset_pin_oe) |-> $past(ctrl_wr, 2))
        else $error("pin pulse without request");
    a_pulse_len: assert property ($fell(reset_pin_oe) |-> hcnt == (PULSE_CNT_W'(2) << len))
        else $error("pin pulse length wrong");
    a_startup_hold: assert property (scnt < STARTUP_CYCLES |-> !proc_nreset && !periph_nreset)
        else $error("reset released before startup count");
    a_ext_hold: assert property (s_ext_low [*5] |=> !proc_nreset)
        else $error("reset released while pin held low");
    a_irq_no_reset: assert property ($rose(user_reset_irq) |-> proc_nreset && periph_nreset)
        else $error("interrupt came with a reset");
endmodule
`default_nettype wire

// File: test/rcpm_pin_partner.sv
// Purpose: external side of the open-drain reset pin
// Assumes: pull-up on the line
// Notes: released line reads high, never a stale level
`timescale 1ns/1ps
`default_nettype none
module rcpm_pin_partner (
    input wire logic pin_o,
    input wire logic pin_oe,
    input wire logic hold_low,
    output logic pin
);
    assign pin = ((pin_oe && !pin_o) || hold_low) ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// File: test/tb_reset_ctrl_pin_manager.sv
// Purpose: self-checking bench of the reset controller
// Assumes: short startup count, pull-up on the reset pin
// Notes: scenarios run in one sequence; pin held low by the partner on demand
`timescale 1ns/1ps
`default_nettype none
module tb_reset_ctrl_pin_manager
    import rcpm_pkg::*;
;
    localparam int SC = 20;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [ADR_W-1:0] adr = '0;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic hold_low = 1'b0;
    wire logic [31:0] rdat;
    wire logic ack, pin, pin_o, pin_oe, proc_n, periph_n, irq;
    logic [31:0] rd;
    int errors = 0;
    int n_tests = 0;
    int low_cnt = 0;
    always #2.5 mclk = ~mclk;
    always @(posedge mclk) begin
        if (proc_n !== 1'b1) low_cnt++;
    end
    rcpm_reset_ctrl #(.STARTUP_CYCLES(SC)) dut (.mclk(mclk), .reset_n(reset_n),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .reset_pin_i(pin),
        .reset_pin_o(pin_o), .reset_pin_oe(pin_oe), .proc_nreset(proc_n),
        .periph_nreset(periph_n), .user_reset_irq(irq));
    rcpm_pin_partner u_pin (.pin_o(pin_o), .pin_oe(pin_oe), .hold_low(hold_low), .pin(pin));
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hf;
        do @(posedge mclk); while (ack !== 1'b1);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic pin_low(input int n);
        @(posedge mclk);
        hold_low <= 1'b1;
        repeat (n) @(posedge mclk);
        hold_low <= 1'b0;
    endtask
    task automatic t_startup();
        repeat (SC - 4) @(posedge mclk);
        chk("proc startup", 0, proc_n);
        xfer(1'b0, ADDR_MODE, 32'h0);
        chk("mode reset", 32'h1, rd);
        repeat (20) @(posedge mclk);
        chk("proc up", 1, proc_n);
        xfer(1'b0, ADDR_STATUS, 32'h0);
        chk("status reset", (32'h1 << STAT_PIN_BIT) | (32'(TYPE_POWERUP) << STAT_TYPE_LSB), rd);
        xfer(1'b1, 4'hc, 32'hffff_ffff);
        xfer(1'b0, 4'hc, 32'h0);
        chk("unmapped", 0, rd);
        xfer(1'b0, ADDR_MODE, 32'h0);
        chk("mode kept", 32'h1, rd);
    endtask
    task automatic t_pulse(input logic [LEN_W-1:0] f);
        int n;
        int lc;
        n = 0;
        lc = low_cnt;
        xfer(1'b1, ADDR_MODE, (32'(f) << MODE_LEN_LSB) | 32'h1);
        xfer(1'b1, ADDR_CTRL, 32'h1 << CTRL_EXT_BIT);
        repeat (80) begin
            @(posedge mclk);
            if (pin_oe === 1'b1) n++;
        end
        chk("pulse cycles", 32'h2 << f, 32'(n));
        chk("proc low", 0, 32'(low_cnt - lc));
        xfer(1'b0, ADDR_STATUS, 32'h0);
        chk("status set", 1, rd[STAT_URST_BIT]);
        xfer(1'b0, ADDR_STATUS, 32'h0);
        chk("status clear", 0, rd[STAT_URST_BIT]);
    endtask
    task automatic t_soft();
        xfer(1'b1, ADDR_CTRL, (32'h1 << CTRL_PROC_BIT) | (32'h1 << CTRL_PERIPH_BIT));
        @(posedge mclk);
        #1;
        chk("proc soft", 0, proc_n);
        chk("periph soft", 0, periph_n);
        repeat (6) @(posedge mclk);
        xfer(1'b0, ADDR_STATUS, 32'h0);
        chk("type soft", 32'(TYPE_SOFT), 32'(rd[STAT_TYPE_LSB +: TYPE_W]));
        xfer(1'b1, ADDR_CTRL, 32'h1 << CTRL_PERIPH_BIT);
        @(posedge mclk);
        #1;
        chk("periph alone", 0, periph_n);
        chk("proc alone", 1, proc_n);
        repeat (6) @(posedge mclk);
    endtask
    task automatic t_user();
        int n;
        n = 0;
        @(posedge mclk);
        hold_low <= 1'b1;
        repeat (14) @(posedge mclk);
        #1;
        chk("proc user", 0, proc_n);
        chk("periph user", 0, periph_n);
        @(posedge mclk);
        hold_low <= 1'b0;
        while (proc_n !== 1'b1 && n < 40) begin
            @(posedge mclk);
            n++;
        end
        chk("exit delay", 1, 32'(n >= 5 && n <= 12));
        xfer(1'b0, ADDR_STATUS, 32'h0);
        chk("type user", 32'(TYPE_USER), 32'(rd[STAT_TYPE_LSB +: TYPE_W]));
        chk("status user", 1, rd[STAT_URST_BIT]);
    endtask
    task automatic t_nouser();
        int lc;
        xfer(1'b1, ADDR_MODE, 32'h0);
        lc = low_cnt;
        @(posedge mclk);
        hold_low <= 1'b1;
        repeat (10) @(posedge mclk);
        xfer(1'b0, ADDR_STATUS, 32'h0);
        chk("level low", 0, rd[STAT_PIN_BIT]);
        chk("status low", 1, rd[STAT_URST_BIT]);
        hold_low <= 1'b0;
        repeat (10) @(posedge mclk);
        chk("no user reset", 0, 32'(low_cnt - lc));
        xfer(1'b0, ADDR_STATUS, 32'h0);
        chk("level high", 1, rd[STAT_PIN_BIT]);
    endtask
    task automatic t_irq();
        int lc;
        xfer(1'b1, ADDR_MODE, (32'h1 << MODE_IRQ_EN_BIT) | 32'h1);
        lc = low_cnt;
        pin_low(10);
        #1;
        chk("irq up", 1, irq);
        repeat (10) @(posedge mclk);
        chk("irq held", 1, irq);
        chk("irq no reset", 0, 32'(low_cnt - lc));
        xfer(1'b0, ADDR_STATUS, 32'h0);
        repeat (2) @(posedge mclk);
        #1;
        chk("irq down", 0, irq);
        xfer(1'b1, ADDR_MODE, 32'h1);
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        #100000;
        errors++;
        wrap_up();
    end
    initial begin
        repeat (16) @(posedge mclk);
        reset_n <= 1'b1;
        t_startup();
        t_pulse(4'h0);
        t_pulse(4'h3);
        t_soft();
        t_user();
        t_nouser();
        t_irq();
        wrap_up();
    end
endmodule
bind rcpm_reset_ctrl rcpm_reset_ctrl_props #(.STARTUP_CYCLES(STARTUP_CYCLES)) u_props (
    .mclk(mclk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .reset_pin_i(reset_pin_i),
    .reset_pin_o(reset_pin_o), .reset_pin_oe(reset_pin_oe), .proc_nreset(proc_nreset),
    .periph_nreset(periph_nreset), .user_reset_irq(user_reset_irq));
`default_nettype wire
